// ==== rtl/cdg_glue.sv ====
// Glue logic joining a multiplexed-bus processor to a byte-wide DMA controller
// Operation
// - DMA puts low address on pins, high on data
// - High latch loads only on upper strobe
// - Select needs top 12 bits match base
// - Select only during processor I/O status
// - Memory commands driven by glue from processor only
// - I/O commands driven by glue when processor owns
// - Status decoded to I/O and memory qualifiers
// - One of four commands from qualifier, direction
// - Processor commands only while data strobe low
// - Processor commands driven only while grant high
// - Buffer control chosen by grant and write
// - Processor register read enables both halves
// - Processor register write enables lower half only
// - Buffer outward only on selected processor read
// - Copy read enables half by address bit
// - DMA I/O write disables both buffers
// - Copy write enables both halves
// - High latch output enabled from bus grant
// - Processor transceivers on grant, inward on reads
// - Address latched on strobe, output on grant
// - Hold request and grant inverted across
// - I/O decode compares all three status lines
module cdg_glue
  import cdg_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          resetn,
  input  wire logic                          clk_en,
  // Configuration
  input  wire logic [cdg_pkg::CDG_SEL_W-1:0] select_base,
  // Processor bus
  input  wire logic [cdg_pkg::CDG_AW-1:0]    proc_ad_in,
  input  wire logic                          address_strobe_n,
  input  wire logic                          data_strobe_n,
  input  wire logic                          proc_read,
  input  wire logic [cdg_pkg::CDG_STAT_W-1:0] cycle_status_lines,
  input  wire logic                          bus_grant_n,
  output logic                               bus_request_n,
  // DMA controller side
  input  wire logic                          hold_request,
  output logic                               hold_acknowledge,
  input  wire logic [cdg_pkg::CDG_BW-1:0]    dma_data_in,
  input  wire logic                          upper_address_strobe,
  input  wire logic                          address_bit_zero,
  input  wire logic                          dma_mem_read_n,
  input  wire logic                          dma_mem_write_n,
  input  wire logic                          dma_io_read_n,
  input  wire logic                          dma_io_write_n,
  output logic                               dma_select_n,
  output logic [cdg_pkg::CDG_REGSEL_W-1:0]   dma_reg_select,
  // System bus commands
  output logic                               memory_read_cmd_n,
  output logic                               memory_write_cmd_n,
  output logic                               io_read_cmd_n,
  output logic                               io_write_cmd_n,
  output logic                               cmd_oe,
  // Address outputs
  output logic [cdg_pkg::CDG_AW-1:0]         proc_addr_out,
  output logic                               proc_addr_oe,
  output logic [cdg_pkg::CDG_BW-1:0]         upper_addr_out,
  output logic                               upper_addr_oe,
  // Buffer controls
  output logic                               dma_buf_lo_en,
  output logic                               dma_buf_hi_en,
  output logic                               dma_buf_out,
  output logic                               proc_xcvr_en,
  output logic                               proc_xcvr_in
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Every pin passes two stages; stage one feeds stage two only.
  localparam int SW = CDG_AW + 3 + CDG_BW + CDG_SEL_W + CDG_STAT_W + 8;
  // Idle pin levels, so no false strobe or grant shows after reset
  localparam logic [SW-1:0] SYNC_IDLE = {CDG_ADDR_RST, 3'h6, CDG_HI_RST, CDG_BASE_DEF,
                                         3'h0, 1'b1, 3'h0, 4'hF};
  logic [SW-1:0] s1;
  logic [SW-1:0] s2;
  wire  [SW-1:0] raw = {proc_ad_in, address_strobe_n, data_strobe_n, proc_read,
                        dma_data_in, select_base, cycle_status_lines, bus_grant_n,
                        hold_request, upper_address_strobe, address_bit_zero,
                        dma_mem_read_n, dma_mem_write_n, dma_io_read_n,
                        dma_io_write_n};

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      s1 <= SYNC_IDLE;
      s2 <= SYNC_IDLE;
    end
    else if (clk_en)
    begin
      s1 <= raw;
      s2 <= s1;
    end
  end

  // ****************************************
  // Synchronised pins
  // ****************************************
  logic [15:0] ad_s;
  logic        astb_n_s;
  logic        dstb_n_s;
  logic        rd_s;
  logic [7:0]  dd_s;
  logic [11:0] base_s;
  logic [2:0]  st_s;
  logic        gnt_n_s;
  logic        hold_req_s;
  logic        ustb_s;
  logic        a0_s;
  logic        dmr_n_s;
  logic        dmw_n_s;
  logic        dir_n_s;
  logic        diw_n_s;
  assign {ad_s, astb_n_s, dstb_n_s, rd_s, dd_s, base_s, st_s, gnt_n_s, hold_req_s, ustb_s,
          a0_s, dmr_n_s, dmw_n_s, dir_n_s, diw_n_s} = s2;

  // ****************************************
  // Address latches
  // ****************************************
  logic [15:0] addr_lat;
  logic [7:0]  hi_lat;

  // Transparent while the strobe is low, holds once it rises
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_lat <= CDG_ADDR_RST;
    end
    else if (clk_en)
    begin
      if (!astb_n_s)
        addr_lat <= ad_s;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      hi_lat <= CDG_HI_RST;
    else if (clk_en && ustb_s)
      hi_lat <= dd_s;
  end

  // ****************************************
  // Decode
  // ****************************************
  logic cpu_owns;
  logic io_access_decode_n;
  logic memory_access_decode_n;
  logic sel_n;
  logic p_mr_n;
  logic p_mw_n;
  logic p_ir_n;
  logic p_iw_n;
  logic mr_n;
  logic mw_n;
  logic ir_n;
  logic iw_n;
  logic no_write_active_n;
  logic io_access_flag;
  logic b_lo;
  logic b_hi;
  logic b_out;

  always_comb
  begin
    cpu_owns = gnt_n_s;
    // All three status lines compared, so only status CDG_ST_IO decodes as I/O
    io_access_decode_n     = !(st_s == CDG_ST_IO);
    memory_access_decode_n = !(st_s == CDG_ST_MEM0 || st_s == CDG_ST_MEM1);
    sel_n = !(!io_access_decode_n
              && addr_lat[CDG_AW-1:CDG_SEL_LSB] == base_s);
    // One command only, gated by the data strobe
    p_ir_n = !(!dstb_n_s && !io_access_decode_n && rd_s);
    p_iw_n = !(!dstb_n_s && !io_access_decode_n && !rd_s);
    p_mr_n = !(!dstb_n_s && !memory_access_decode_n && rd_s);
    p_mw_n = !(!dstb_n_s && !memory_access_decode_n && !rd_s);
    mr_n = cpu_owns ? p_mr_n : dmr_n_s;
    mw_n = cpu_owns ? p_mw_n : dmw_n_s;
    ir_n = cpu_owns ? p_ir_n : dir_n_s;
    iw_n = cpu_owns ? p_iw_n : diw_n_s;
    no_write_active_n = !(mw_n && iw_n);
    io_access_flag    = !dir_n_s || !diw_n_s;
  end

  // ****************************************
  // Buffer steering
  // ****************************************
  // Grant and the write indicator pick one of four steering rows
  always_comb
  begin
    b_lo  = 1'b0;
    b_hi  = 1'b0;
    b_out = 1'b0;
    case ({cpu_owns, no_write_active_n})
      2'b10:
      begin
        b_lo  = !sel_n;
        b_hi  = !sel_n;
        b_out = !ir_n && !sel_n;
      end
      2'b11:
      begin
        b_lo  = !sel_n;
        b_out = !ir_n && !sel_n;
      end
      2'b00:
      begin
        b_lo = a0_s;
        b_hi = !a0_s;
      end
      2'b01:
      begin
        b_lo = !io_access_flag;
        b_hi = !io_access_flag;
      end
      default:
      begin
        b_lo  = 1'b0;
        b_hi  = 1'b0;
        b_out = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Bus exchange
  // ****************************************
  // Outputs follow synchronised bus state one clock later; no other state kept.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_request_n    <= 1'b1;
      hold_acknowledge <= 1'b0;
    end
    else if (clk_en)
    begin
      bus_request_n    <= !hold_req_s;
      hold_acknowledge <= !gnt_n_s;
    end
  end

  // ****************************************
  // Controller select
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      dma_select_n   <= 1'b1;
      dma_reg_select <= '0;
    end
    else if (clk_en)
    begin
      dma_select_n   <= sel_n;
      dma_reg_select <= addr_lat[CDG_REGSEL_W-1:0];
    end
  end

  // ****************************************
  // System commands
  // ****************************************
  // Commands register even while the controller owns; cmd_oe masks them
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      memory_read_cmd_n  <= 1'b1;
      memory_write_cmd_n <= 1'b1;
      io_read_cmd_n      <= 1'b1;
      io_write_cmd_n     <= 1'b1;
      cmd_oe             <= 1'b0;
    end
    else if (clk_en)
    begin
      memory_read_cmd_n  <= p_mr_n;
      memory_write_cmd_n <= p_mw_n;
      io_read_cmd_n      <= p_ir_n;
      io_write_cmd_n     <= p_iw_n;
      cmd_oe             <= cpu_owns;
    end
  end

  // ****************************************
  // Address drivers
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      proc_addr_out  <= CDG_ADDR_RST;
      proc_addr_oe   <= 1'b0;
      upper_addr_out <= CDG_HI_RST;
      upper_addr_oe  <= 1'b0;
    end
    else if (clk_en)
    begin
      proc_addr_out  <= addr_lat;
      proc_addr_oe   <= cpu_owns;
      upper_addr_out <= hi_lat;
      upper_addr_oe  <= !gnt_n_s;
    end
  end

  // ****************************************
  // Buffer controls
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      dma_buf_lo_en <= 1'b0;
      dma_buf_hi_en <= 1'b0;
      dma_buf_out   <= 1'b0;
      proc_xcvr_en  <= 1'b0;
      proc_xcvr_in  <= 1'b0;
    end
    else if (clk_en)
    begin
      dma_buf_lo_en <= b_lo;
      dma_buf_hi_en <= b_hi;
      dma_buf_out   <= b_out;
      proc_xcvr_en  <= cpu_owns;
      proc_xcvr_in  <= !ir_n || !mr_n;
    end
  end

  // Peripheral request handshake stays between peripheral and controller

endmodule

// ==== pkg/cdg_pkg.sv ====
// Package: constants for the processor to DMA controller glue logic
package cdg_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int CDG_AW       = 16;
  localparam int CDG_BW       = 8;
  localparam int CDG_SEL_W    = 12;
  localparam int CDG_REGSEL_W = 4;
  localparam int CDG_STAT_W   = 3;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CDG_SEL_LSB  = 4;
  localparam int CDG_HI_LSB   = 8;

  // ****************************************
  // Status decodes (status lines 3..1)
  // ****************************************
  localparam logic [2:0] CDG_ST_IO     = 3'h1;
  localparam logic [2:0] CDG_ST_MEM0   = 3'h4;
  localparam logic [2:0] CDG_ST_MEM1   = 3'h6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] CDG_ADDR_RST = 16'h0000;
  localparam logic [7:0]  CDG_HI_RST   = 8'h00;
  localparam logic [11:0] CDG_BASE_DEF = 12'h000;

endpackage

// ==== dv/cdg_asserts.sv ====
// Checker of port timing for the glue logic
module cdg_asserts
(
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // Watched inputs
  input wire logic hold_request,
  input wire logic bus_grant_n,
  input wire logic data_strobe_n,
  // Watched outputs
  input wire logic bus_request_n,
  input wire logic hold_acknowledge,
  input wire logic cmd_oe,
  input wire logic proc_xcvr_en,
  input wire logic upper_addr_oe,
  input wire logic dma_buf_hi_en,
  input wire logic memory_read_cmd_n,
  input wire logic memory_write_cmd_n,
  input wire logic io_read_cmd_n,
  input wire logic io_write_cmd_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] age;
  wire logic [3:0] cmd_n = {memory_read_cmd_n, memory_write_cmd_n, io_read_cmd_n, io_write_cmd_n};
  // Outputs trail inputs by three enabled edges; a freeze restarts the count
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      age <= 2'h0;
    else if (!clk_en)
      age <= 2'h0;
    else if (age != 2'h3)
      age <= age + 2'h1;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_settled;
    age == 2'h3;
  endsequence
  a_req_inverts: assert property (s_settled |-> bus_request_n == !$past(hold_request, 3))
    else $error("bad bus request");
  a_ack_inverts: assert property (s_settled |-> hold_acknowledge == !$past(bus_grant_n, 3))
    else $error("bad hold acknowledge");
  a_cmd_oe_grant: assert property (s_settled |-> cmd_oe == $past(bus_grant_n, 3))
    else $error("bad command enable");
  a_xcvr_grant: assert property (s_settled |-> proc_xcvr_en == $past(bus_grant_n, 3))
    else $error("bad transceiver enable");
  a_upper_oe_grant: assert property (s_settled |-> upper_addr_oe == !$past(bus_grant_n, 3))
    else $error("bad upper address enable");
  a_cmd_on_strobe: assert property (s_settled ##0 cmd_n != 4'hF |-> !$past(data_strobe_n, 3))
    else $error("command without strobe");
  a_one_cmd: assert property ($onehot0(~cmd_n))
    else $error("several commands");
  a_write_lo_only: assert property (cmd_oe && !io_write_cmd_n |-> !dma_buf_hi_en)
    else $error("upper buffer on write");
endmodule

// ==== dv/cdg_partner.sv ====
// Model of the processor that owns the bus until it grants it away
module cdg_partner
(
  // Clock and request
  input  wire logic   clk_sys, bus_request_n,
  // Processor bus
  output logic        bus_grant_n, address_strobe_n, data_strobe_n, proc_read,
  output logic [15:0] proc_ad_in,
  output logic [2:0]  cycle_status_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {bus_grant_n, address_strobe_n, data_strobe_n, proc_read} = 4'hF;
    {proc_ad_in, cycle_status_lines} = 19'h00000;
  end
  always @(posedge clk_sys)
    bus_grant_n <= #1 bus_request_n;
  // Released bus must not look like a held value
  always @(posedge clk_sys)
    if (!bus_grant_n)
      proc_ad_in <= #1 ~proc_ad_in;
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic cyc(input logic [15:0] a, input logic [2:0] s, input logic rd);
    {proc_ad_in, cycle_status_lines, proc_read, address_strobe_n} = {a, s, rd, 1'b0};
    step(4);
    address_strobe_n = 1'b1;
    step(1);
    // Data replaces the address, so the latch must hold
    {proc_ad_in, data_strobe_n} = {~a, 1'b0};
    step(6);
  endtask
  task automatic fin;
    {data_strobe_n, cycle_status_lines} = 4'h8;
  endtask
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench of the processor to DMA glue logic
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cdg_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, clk_en, hold_request;
  logic upper_address_strobe, address_bit_zero, dma_io_write_n;
  logic dma_mem_read_n, dma_mem_write_n, dma_io_read_n;
  logic bus_grant_n, bus_request_n, address_strobe_n, data_strobe_n, proc_read;
  logic hold_acknowledge, dma_select_n, cmd_oe, proc_addr_oe, upper_addr_oe, dma_buf_lo_en;
  logic dma_buf_hi_en, dma_buf_out, proc_xcvr_en, proc_xcvr_in, memory_read_cmd_n;
  logic memory_write_cmd_n, io_read_cmd_n, io_write_cmd_n;
  logic [3:0] dma_reg_select;
  logic [2:0] cycle_status_lines;
  logic [7:0] dma_data_in, upper_addr_out;
  logic [11:0] select_base;
  logic [15:0] proc_ad_in, proc_addr_out;
  int error_cnt = 0, checks_done = 0, ticks = 0;
  wire logic [15:0] obs = {1'b0, bus_request_n, hold_acknowledge, cmd_oe, proc_xcvr_en,
    proc_addr_oe, upper_addr_oe, proc_xcvr_in, memory_read_cmd_n, memory_write_cmd_n,
    io_read_cmd_n, io_write_cmd_n, dma_select_n, dma_buf_lo_en, dma_buf_hi_en, dma_buf_out};
  cdg_partner u_p (.*);
  cdg_glue u_dut (.*);
  always #5 clk_sys = ~clk_sys;
  // Run takes some 240 cycles
  always @(posedge clk_sys)
    if (ticks++ == 3000)
      end_of_test(1);
  task automatic end_of_test(input int hung);
    error_cnt += hung;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    error_cnt += int'(g !== e);
    if (g !== e)
      $display("ERROR %s expected %h seen %h", n, e, g);
  endtask
  task automatic t_dma;
    logic [4:0] d [5] = '{5'h0F, 5'h0E, 5'h16, 5'h0C, 5'h13};
    logic [1:0] e [5] = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h0};
    hold_request = 1'b1;
    u_p.step(10);
    chk("grant", 16'h2200, obs & 16'h7E00);
    {dma_data_in, upper_address_strobe} = {8'h5A, 1'b1};
    u_p.step(1);
    upper_address_strobe = 1'b0;
    u_p.step(1);
    dma_data_in = 8'hC3;
    u_p.step(5);
    chk("upper", 16'h005A, {8'h00, upper_addr_out});
    for (int i = 0; i < 5; i++)
    begin
      {dma_mem_read_n, dma_mem_write_n, dma_io_read_n, dma_io_write_n, address_bit_zero} = d[i];
      u_p.step(5);
      chk("buffers", {13'h0000, e[i], 1'b0}, obs & 16'h0006);
    end
    {dma_mem_read_n, dma_mem_write_n, dma_io_read_n, dma_io_write_n} = 4'hF;
    hold_request = 1'b0;
    u_p.step(10);
  endtask
  task automatic t_freeze;
    clk_en = 1'b0;
    hold_request = 1'b1;
    u_p.step(6);
    chk("frozen", 16'h4000, obs & 16'h4000);
    clk_en = 1'b1;
    u_p.step(5);
    chk("resumed", 16'h0000, obs & 16'h4000);
    hold_request = 1'b0;
    u_p.step(12);
  endtask
  task automatic t_proc;
    logic [2:0] st [5] = '{CDG_ST_IO, CDG_ST_IO, CDG_ST_MEM0, CDG_ST_MEM1, 3'h0};
    logic [15:0] a, e;
    logic [2:0] s;
    logic rd, io, mem, sel;
    for (int i = 0; i < 10; i++)
    begin
      s = st[i % 5];
      rd = (i % 5) != 1 && (i % 5) != 3;
      io = s == CDG_ST_IO;
      mem = s == CDG_ST_MEM0 || s == CDG_ST_MEM1;
      sel = io && i < 5;
      a = {select_base ^ ((i < 5) ? 12'h000 : 12'h010), 4'h9};
      e = {7'h2E, rd && (io || mem), ~{mem && rd, mem && !rd, io && rd, io && !rd},
        !sel, sel, sel && rd, sel && rd};
      u_p.cyc(a, s, rd);
      chk("address", a, proc_addr_out);
      chk("regsel", {12'h000, a[3:0]}, {12'h000, dma_reg_select});
      chk("outputs", e, obs);
      u_p.fin;
      u_p.step(5);
      chk("idle", 16'h00F0, obs & 16'h00F0);
    end
  endtask
  initial
  begin
    {clk_en, hold_request, upper_address_strobe, address_bit_zero} = 4'h8;
    {dma_mem_read_n, dma_mem_write_n, dma_io_read_n, dma_io_write_n} = 4'hF;
    {dma_data_in, select_base} = 20'h00A5C;
    repeat (2) @(posedge clk_sys);
    #1 resetn = 1'b1;
    u_p.step(4);
    t_dma;
    t_freeze;
    t_proc;
    end_of_test(0);
  end
endmodule

bind cdg_glue cdg_asserts u_chk (.*);
